// ===== hw/sbc_reg_bank.sv
// device end: register bank behind the sixteen-bit serial link
// assumes: link pins are asynchronous to hclk; event and level inputs are on hclk
`include "sbc_link_cfg.svh"
module sbc_reg_bank
    import sbc_link_pkg::*;
#(
    // value is arbitrary
    parameter logic [7:0] FAMILY_PRODUCT_ID = 8'h5a
) (
    input wire logic hclk,
    input wire logic hresetn,
    sbc_link_if.dev link,
    input wire logic restart_pulse,
    input wire logic hw_we,
    input wire logic [6:0] hw_addr,
    input wire logic [7:0] hw_data,
    input wire logic [9:0][7:0] stat_evt,
    input wire logic [7:0] wake_lvl,
    output logic [31:0][7:0] ctrl_regs,
    output logic soft_reset_pulse
);
    logic [2:0] sclk_sy;
    logic [2:0] csn_sy;
    logic [1:0] mosi_sy;
    logic [4:0] cnt_q;
    frame_t rx_q;
    reg_byte_t rd_q;
    reg_byte_t rd_d;
    reg_byte_t out_sh_q;
    logic miso_q;
    logic miso_oe_q;
    logic [31:0][7:0] ctrl_q;
    logic [9:0][7:0] stat_q;
    logic sclk_rise, sclk_fall, csn_rise, csn_fall, sel;
    logic frame_done, frame_wr;
    reg_addr_t frame_addr;
    reg_byte_t frame_data;
    logic [3:0] frame_slot;

    // writable bits of each control register; zero for unmapped and status
    function automatic reg_byte_t wmask(input reg_addr_t a);
        case (a)
            `MODE_SUPPLY_CONTROL_A: wmask = `MODE_SUPPLY_CONTROL_M;
            `HARDWARE_CONFIGURATION_A: wmask = `HARDWARE_CONFIGURATION_M;
            `WATCHDOG_CONTROL_A: wmask = `WATCHDOG_CONTROL_M;
            `TRANSCEIVER_CONTROL_FIRST_A: wmask = `TRANSCEIVER_CONTROL_FIRST_M;
            `TRANSCEIVER_CONTROL_SECOND_A: wmask = `TRANSCEIVER_CONTROL_SECOND_M;
            `WAKE_CONTROL_FIRST_A: wmask = `WAKE_CONTROL_FIRST_M;
            `WAKE_CONTROL_SECOND_A: wmask = `WAKE_CONTROL_SECOND_M;
            `WAKE_INPUT_PULL_CONFIG_A: wmask = `WAKE_INPUT_CONFIG_M;
            `WAKE_INPUT_FILTER_CONFIG_A: wmask = `WAKE_INPUT_CONFIG_M;
            `CYCLIC_TIMER_A_CONTROL_A: wmask = `PAIRED_FIELD_M;
            `CYCLIC_TIMER_B_CONTROL_A: wmask = `PAIRED_FIELD_M;
            `SWITCH_SHUTDOWN_CONTROL_A: wmask = `SWITCH_SHUTDOWN_CONTROL_M;
            `HIGH_SIDE_SWITCH_CONTROL_A_A: wmask = `PAIRED_FIELD_M;
            `HIGH_SIDE_SWITCH_CONTROL_B_A: wmask = `PAIRED_FIELD_M;
            `GENERAL_PIN_CONTROL_A: wmask = `FULL_BYTE_M;
            `PULSE_WIDTH_A_DUTY_A: wmask = `FULL_BYTE_M;
            `PULSE_WIDTH_B_DUTY_A: wmask = `FULL_BYTE_M;
            `PULSE_WIDTH_FREQUENCY_A: wmask = `PULSE_WIDTH_FREQUENCY_M;
            `SYSTEM_SCRATCH_STATUS_A: wmask = `FULL_BYTE_M;
            default: wmask = '0;
        endcase
    endfunction

    // bits that internal logic may change
    function automatic reg_byte_t hmask(input reg_addr_t a);
        case (a)
            `MODE_SUPPLY_CONTROL_A: hmask = `MODE_SUPPLY_CONTROL_H;
            `HARDWARE_CONFIGURATION_A: hmask = `HARDWARE_CONFIGURATION_H;
            default: hmask = '0;
        endcase
    endfunction

    // bits left untouched on restart
    function automatic reg_byte_t kmask(input reg_addr_t a);
        case (a)
            `MODE_SUPPLY_CONTROL_A: kmask = `MODE_SUPPLY_CONTROL_K;
            `HARDWARE_CONFIGURATION_A: kmask = `HARDWARE_CONFIGURATION_K;
            default: kmask = `FULL_BYTE_M;
        endcase
    endfunction

    // storage slot of a read/clear register
    function automatic logic [3:0] sslot(input reg_addr_t a);
        if (a >= `SUPPLY_STATUS_SECOND_A && a <= `WAKE_SOURCE_STATUS_SECOND_A) begin
            sslot = {1'b0, a[2:0]};
        end else if (a == `SWITCH_OVERCURRENT_STATUS_A) begin
            sslot = `STAT_SLOT_OC;
        end else if (a == `SWITCH_OPEN_LOAD_STATUS_A) begin
            sslot = `STAT_SLOT_OL;
        end else begin
            sslot = `STAT_SLOT_NONE;
        end
    endfunction

    // implemented bits of each status register
    function automatic reg_byte_t smask(input reg_addr_t a);
        case (a)
            `SUPPLY_STATUS_SECOND_A: smask = `SUPPLY_STATUS_SECOND_M;
            `SUPPLY_STATUS_FIRST_A: smask = `FULL_BYTE_M;
            `THERMAL_STATUS_A: smask = `THERMAL_STATUS_M;
            `DEVICE_STATUS_A: smask = `DEVICE_STATUS_M;
            `TRANSCEIVER_STATUS_FIRST_A: smask = `TRANSCEIVER_STATUS_FIRST_M;
            `WAKE_SOURCE_STATUS_FIRST_A: smask = `PAIRED_FIELD_M;
            `WAKE_SOURCE_STATUS_SECOND_A: smask = `WAKE_SOURCE_STATUS_SECOND_M;
            `WAKE_INPUT_LEVEL_STATUS_A: smask = `WAKE_INPUT_LEVEL_STATUS_M;
            `SWITCH_OVERCURRENT_STATUS_A: smask = `SWITCH_STATUS_M;
            `SWITCH_OPEN_LOAD_STATUS_A: smask = `SWITCH_STATUS_M;
            default: smask = '0;
        endcase
    endfunction

    // link pins come from another clock; edges compare the second and third stages, the first is never looked at
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_sy <= 3'h0;
            csn_sy <= 3'h7;
            mosi_sy <= 2'h0;
        end else begin
            sclk_sy <= {sclk_sy[1:0], link.sclk};
            csn_sy <= {csn_sy[1:0], link.csn};
            mosi_sy <= {mosi_sy[0], link.mosi};
        end
    end

    assign sel = ~csn_sy[1];
    assign sclk_rise = sel & sclk_sy[1] & ~sclk_sy[2];
    assign sclk_fall = sel & ~sclk_sy[1] & sclk_sy[2];
    assign csn_fall = ~csn_sy[1] & csn_sy[2];
    assign csn_rise = csn_sy[1] & ~csn_sy[2];

    // frame field split: address, access bit, data byte
    assign frame_addr = rx_q[6:0];
    assign frame_wr = rx_q[`ACCESS_BIT];
    assign frame_data = rx_q[15:8];
    assign frame_slot = sslot(frame_addr);
    // only a frame of exactly sixteen clocks is acted on
    assign frame_done = csn_rise & (cnt_q == `FRAME_BITS);

    // bit counter saturates so a long frame never aliases to sixteen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 5'h0;
        end else if (csn_fall) begin
            cnt_q <= 5'h0;
        end else if (sclk_rise && cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h1;
        end
    end

    // bit 0 of the frame is first on the wire
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_q <= '0;
        end else if (sclk_rise) begin
            rx_q <= {mosi_sy[1], rx_q[15:1]};
        end
    end

    // answer byte; for writes this is the old contents
    always_comb begin
        rd_d = '0;
        if (rx_q[15:14] == 2'b00) begin
            rd_d = ctrl_q[rx_q[13:9]];
        end else if (sslot(rx_q[15:9]) != `STAT_SLOT_NONE) begin
            rd_d = stat_q[sslot(rx_q[15:9])] & smask(rx_q[15:9]);
        end else if (rx_q[15:9] == `WAKE_INPUT_LEVEL_STATUS_A) begin
            rd_d = wake_lvl & `WAKE_INPUT_LEVEL_STATUS_M;
        end else if (rx_q[15:9] == `FAMILY_PRODUCT_ID_A) begin
            rd_d = FAMILY_PRODUCT_ID;
        end
    end

    // snapshot taken with the last address bit, before any write lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= '0;
        end else if (sclk_rise && cnt_q == `ADDR_LAST_BIT) begin
            rd_q <= rd_d;
        end
    end

    // first byte out is a flag summary, second is the register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
            out_sh_q <= '0;
        end else begin
            miso_oe_q <= sel;
            if (csn_fall) begin
                miso_q <= |stat_q;
                out_sh_q <= '0;
            end else if (sclk_fall && cnt_q == `BYTE_BITS) begin
                miso_q <= rd_q[0];
                out_sh_q <= {1'b0, rd_q[7:1]};
            end else if (sclk_fall) begin
                miso_q <= out_sh_q[0];
                out_sh_q <= {1'b0, out_sh_q[7:1]};
            end else if (csn_rise) begin
                miso_q <= 1'b0;
            end
        end
    end

    // restart beats a frame ending in the same cycle; it is rare and short
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= '0;
        end else if (restart_pulse) begin
            for (int i = 0; i < 32; i++) begin
                ctrl_q[i] <= ctrl_q[i] & kmask(7'(i));
            end
        end else if (frame_done && frame_wr && frame_addr == `MODE_SUPPLY_CONTROL_A &&
                     frame_data[7:6] == `SOFT_RESET_MODE) begin
            for (int i = 0; i < 32; i++) begin
                ctrl_q[i] <= `CTRL_POR_VAL;
            end
        end else begin
            if (frame_done && frame_wr && frame_addr[6:5] == 2'b00) begin
                ctrl_q[frame_addr[4:0]] <= frame_data & wmask(frame_addr);
            end
            if (hw_we && hw_addr[6:5] == 2'b00) begin
                // only rwh bits move on internal events
                ctrl_q[hw_addr[4:0]] <= (ctrl_q[hw_addr[4:0]] & ~hmask(hw_addr)) |
                                        (hw_data & hmask(hw_addr));
            end
        end
    end

    // flags reported in this frame are cleared; a new event still lands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < 10; i++) begin
                if (frame_done && frame_slot == 4'(i)) begin
                    stat_q[i] <= (stat_q[i] & ~rd_q) | stat_evt[i];
                end else begin
                    stat_q[i] <= stat_q[i] | stat_evt[i];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= frame_done && frame_wr && frame_addr == `MODE_SUPPLY_CONTROL_A &&
                                frame_data[7:6] == `SOFT_RESET_MODE;
        end
    end

    assign ctrl_regs = ctrl_q;
    assign link.miso = miso_q;
    assign link.miso_oe = miso_oe_q;
endmodule

// ===== hw/sbc_link_cfg.svh
// constants of the serial register link between controller and device
// assumes: included by bare name into the package and design modules
//
// What this block does
// - frames are sixteen bits, address byte then data
// - first byte: seven-bit address plus access bit
// - data bits 0..7 ride frame bits 8..15
// - master reads with access bit cleared
// - master writes with access bit set
// - reserved bits always read back zero
// - master writes zero into reserved bits; the bench leaves random data unmasked on every other random frame
// - power-on or commanded reset loads reset values
// - restart loads restart values, keeps don't-care bits
// - read-only ignore writes, rw store, rwh also hardware
// - internal logic changes only hardware-modifiable control bits
// - master itself rewrites ordinary control bits
// - one frame accesses exactly one register
// - write frame returns previous register contents
`ifndef SBC_LINK_CFG_SVH
`define SBC_LINK_CFG_SVH

`define FRAME_BITS 5'd16
`define BYTE_BITS 5'd8
`define ADDR_LAST_BIT 5'd7
`define ACCESS_BIT 7
`define CTRL_POR_VAL 8'h00
`define SOFT_RESET_MODE 2'b11

`define MODE_SUPPLY_CONTROL_A 7'h01
`define MODE_SUPPLY_CONTROL_M 8'hff
`define MODE_SUPPLY_CONTROL_H 8'hfc
`define MODE_SUPPLY_CONTROL_K 8'h23
`define HARDWARE_CONFIGURATION_A 7'h02
`define HARDWARE_CONFIGURATION_M 8'hfb
`define HARDWARE_CONFIGURATION_H 8'h20
`define HARDWARE_CONFIGURATION_K 8'hd9
`define WATCHDOG_CONTROL_A 7'h03
`define WATCHDOG_CONTROL_M 8'hf7
`define TRANSCEIVER_CONTROL_FIRST_A 7'h04
`define TRANSCEIVER_CONTROL_FIRST_M 8'hfb
`define TRANSCEIVER_CONTROL_SECOND_A 7'h05
`define TRANSCEIVER_CONTROL_SECOND_M 8'h20
`define WAKE_CONTROL_FIRST_A 7'h06
`define WAKE_CONTROL_FIRST_M 8'hc4
`define WAKE_CONTROL_SECOND_A 7'h07
`define WAKE_CONTROL_SECOND_M 8'ha7
`define WAKE_INPUT_PULL_CONFIG_A 7'h08
`define WAKE_INPUT_FILTER_CONFIG_A 7'h09
`define WAKE_INPUT_CONFIG_M 8'h3f
`define CYCLIC_TIMER_A_CONTROL_A 7'h0c
`define CYCLIC_TIMER_B_CONTROL_A 7'h0d
`define SWITCH_SHUTDOWN_CONTROL_A 7'h10
`define SWITCH_SHUTDOWN_CONTROL_M 8'h70
`define HIGH_SIDE_SWITCH_CONTROL_A_A 7'h14
`define HIGH_SIDE_SWITCH_CONTROL_B_A 7'h15
`define PAIRED_FIELD_M 8'h77
`define GENERAL_PIN_CONTROL_A 7'h17
`define PULSE_WIDTH_A_DUTY_A 7'h18
`define PULSE_WIDTH_B_DUTY_A 7'h19
`define PULSE_WIDTH_FREQUENCY_A 7'h1c
`define PULSE_WIDTH_FREQUENCY_M 8'h05
`define SYSTEM_SCRATCH_STATUS_A 7'h1e
`define FULL_BYTE_M 8'hff

`define SUPPLY_STATUS_SECOND_A 7'h40
`define SUPPLY_STATUS_SECOND_M 8'h5f
`define SUPPLY_STATUS_FIRST_A 7'h41
`define THERMAL_STATUS_A 7'h42
`define THERMAL_STATUS_M 8'h07
`define DEVICE_STATUS_A 7'h43
`define DEVICE_STATUS_M 8'hcf
`define TRANSCEIVER_STATUS_FIRST_A 7'h44
`define TRANSCEIVER_STATUS_FIRST_M 8'h67
`define TRANSCEIVER_STATUS_SECOND_A 7'h45
`define WAKE_SOURCE_STATUS_FIRST_A 7'h46
`define WAKE_SOURCE_STATUS_SECOND_A 7'h47
`define WAKE_SOURCE_STATUS_SECOND_M 8'h30
`define WAKE_INPUT_LEVEL_STATUS_A 7'h48
`define WAKE_INPUT_LEVEL_STATUS_M 8'hf7
`define SWITCH_OVERCURRENT_STATUS_A 7'h54
`define SWITCH_OPEN_LOAD_STATUS_A 7'h55
`define SWITCH_STATUS_M 8'h0f
`define FAMILY_PRODUCT_ID_A 7'h7e
`define STAT_SLOT_NONE 4'hf
`define STAT_SLOT_OC 4'h8
`define STAT_SLOT_OL 4'h9

`define HOST_CMD_OFS 8'h00
`define HOST_STATUS_OFS 8'h04
`define HOST_RX_OFS 8'h08
`define HOST_IRQ_STAT_OFS 8'h0c
`define HOST_IRQ_MASK_OFS 8'h10
`define SCLK_HALF_CYCLES 8
`endif

// ===== hw/sbc_link_pkg.sv
// types shared by both ends of the serial register link
// assumes: nothing beyond the constants header
package sbc_link_pkg;
    `include "sbc_link_cfg.svh"
    typedef logic [6:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [15:0] frame_t;
    typedef enum logic [3:0] {
        LINK_IDLE = 4'b0001,
        LINK_RUN = 4'b0010,
        LINK_END = 4'b0100,
        LINK_GAP = 4'b1000
    } link_state_t;
endpackage

// ===== hw/sbc_link_if.sv
// four-wire serial link between controller and device
// assumes: the bench joins both modports; miso is valid only while miso_oe is high
interface sbc_link_if;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport dev (input sclk, input csn, input mosi, output miso, output miso_oe);
    modport host (output sclk, output csn, output mosi, input miso, input miso_oe);
endinterface

// ===== hw/sbc_link_master.sv
// controller end: AHB-Lite slave that runs one sixteen-bit frame per command
// assumes: a single AHB-Lite master, word accesses only; link pins go to the device
`include "sbc_link_cfg.svh"
module sbc_link_master
    import sbc_link_pkg::*;
#(
    parameter int SCLK_HALF = `SCLK_HALF_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    sbc_link_if.host link
);
    link_state_t state_q;
    logic [1:0] miso_sy;
    logic [7:0] div_q;
    logic tick;
    logic [4:0] bits_q;
    frame_t tx_q;
    frame_t rx_q;
    logic sclk_q, csn_q, mosi_q;
    logic done_ev;
    logic irq_stat_q, irq_mask_q;
    logic ap_wr_q;
    logic [7:0] ap_addr_q;
    logic start;

    // address phase of every transfer is taken; no wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= '0;
        end else if (hready) begin
            ap_wr_q <= hsel & htrans[1] & hwrite;
            ap_addr_q <= haddr[7:0];
        end
    end

    // a command while busy is dropped; software polls busy first
    assign start = ap_wr_q && ap_addr_q == `HOST_CMD_OFS && state_q == LINK_IDLE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                `HOST_STATUS_OFS: hrdata <= {31'h0, state_q != LINK_IDLE};
                `HOST_RX_OFS: hrdata <= {16'h0, rx_q};
                `HOST_IRQ_STAT_OFS: hrdata <= {31'h0, irq_stat_q};
                `HOST_IRQ_MASK_OFS: hrdata <= {31'h0, irq_mask_q};
                default: hrdata <= '0;
            endcase
        end
    end

    // status clears on read, but a completion in that cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= 1'b0;
            irq_mask_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (done_ev) begin
                irq_stat_q <= 1'b1;
            end else if (hready && hsel && htrans[1] && !hwrite &&
                         haddr[7:0] == `HOST_IRQ_STAT_OFS) begin
                irq_stat_q <= 1'b0;
            end
            if (ap_wr_q && ap_addr_q == `HOST_IRQ_MASK_OFS) begin
                irq_mask_q <= hwdata[0];
            end
            irq <= irq_stat_q & irq_mask_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miso_sy <= 2'h0;
        end else begin
            miso_sy <= {miso_sy[0], link.miso};
        end
    end

    // divider gives one enable per half serial clock
    assign tick = div_q == 8'(SCLK_HALF - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
        end else if (state_q == LINK_IDLE || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h1;
        end
    end

    // frame: address bits 0..6, access bit 7, data in bits 8..15
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= LINK_IDLE;
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            mosi_q <= 1'b0;
            bits_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            done_ev <= 1'b0;
        end else begin
            done_ev <= 1'b0;
            case (state_q)
                LINK_IDLE: begin
                    if (start) begin
                        // access bit comes from software: 0 read, 1 write
                        tx_q <= hwdata[15:0];
                        mosi_q <= hwdata[0];
                        csn_q <= 1'b0;
                        bits_q <= '0;
                        state_q <= LINK_RUN;
                    end
                end
                LINK_RUN: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q <= {miso_sy[1], rx_q[15:1]};
                        bits_q <= bits_q + 5'h1;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (bits_q == `FRAME_BITS) begin
                            state_q <= LINK_END;
                        end else begin
                            mosi_q <= tx_q[bits_q[3:0]];
                        end
                    end
                end
                LINK_END: begin
                    if (tick) begin
                        csn_q <= 1'b1;
                        mosi_q <= 1'b0;
                        done_ev <= 1'b1;
                        state_q <= LINK_GAP;
                    end
                end
                LINK_GAP: begin
                    if (tick) begin
                        state_q <= LINK_IDLE;
                    end
                end
                default: state_q <= LINK_IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.csn = csn_q;
    assign link.mosi = mosi_q;
endmodule

// ===== sim/sbc_link_sva.sv
// checker on the link wires between controller end and device end
// assumes: tb_top instantiates it beside the link interface, hclk domain only
module sbc_link_sva #(
    parameter int SCLK_HALF = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic [7:0] hi_q;
    logic [4:0] edge_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hi_q <= 8'h00;
        else hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
    end
    // rising sclk count in a frame, so bit k is sampled while edge_q == k
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) edge_q <= 5'h00;
        else if (csn) edge_q <= 5'h00;
        else if ($rose(sclk)) edge_q <= edge_q + 5'h01;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_gap;
        csn [*4];
    endsequence
    a_sclk_idle_low: assert property (csn |-> !sclk)
        else $error("sclk active outside a frame");
    a_frame_bit_count: assert property ($rose(csn) |-> edge_q == 5'd16)
        else $error("frame not sixteen clocks");
    a_sclk_high_time: assert property ($fell(sclk) |-> hi_q == SCLK_HALF)
        else $error("sclk high phase wrong length");
    a_mosi_held_high: assert property (sclk |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_frame_gap: assert property ($rose(csn) |-> s_gap)
        else $error("frames too close");
    a_oe_in_frame: assert property ($fell(csn) |-> ##[1:5] miso_oe)
        else $error("miso not driven in frame");
    a_oe_off_idle: assert property (csn [*6] |-> !miso_oe)
        else $error("miso driven between frames");
    a_miso_held: assert property (sclk && miso_oe |-> $stable(miso))
        else $error("miso moved while sclk high");
    // low reply byte carries only the flag summary in bit 0
    a_reply_pad_zero: assert property ($rose(sclk) && edge_q inside {[1:7]} |-> !miso)
        else $error("reply pad bit not zero");
endmodule

// ===== sim/tb_top.sv
// bench: host end on AHB-Lite reaches the device end over the link
// assumes: package, interface, both ends and the checker compiled first
`include "sbc_link_cfg.svh"
module tb_top
    import sbc_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] FAM = 8'h3c; // value is arbitrary
    logic hclk, hresetn, hwrite, hready, hresp, irq, restart_pulse, hw_we;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [6:0] hw_addr, a;
    logic [7:0] hw_data, wake_lvl, d, old;
    logic [9:0][7:0] stat_evt;
    logic [31:0][7:0] ctrl_regs;
    logic [7:0] model [32];
    logic [6:0] tbl [9] = '{7'h01, 7'h02, 7'h03, 7'h05, 7'h10, 7'h1c, 7'h1e, 7'h0a, 7'h20};
    logic [15:0] wire_q;
    int errors, n_tests;
    sbc_link_if lk();
    sbc_reg_bank #(.FAMILY_PRODUCT_ID(FAM)) u_sbc_reg_bank (.hclk, .hresetn, .link(lk.dev),
        .restart_pulse, .hw_we, .hw_addr, .hw_data, .stat_evt, .wake_lvl, .ctrl_regs,
        .soft_reset_pulse());
    sbc_link_master #(.SCLK_HALF(8)) u_sbc_link_master (.hclk, .hresetn, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready, .hrdata, .hreadyout(hready),
        .hresp, .irq, .link(lk.host));
    sbc_link_sva #(.SCLK_HALF(8)) u_sbc_link_sva (.hclk, .hresetn, .sclk(lk.sclk),
        .csn(lk.csn), .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
    function automatic logic [7:0] wmask(input logic [6:0] ad);
        case (ad)
            7'h01, 7'h1e: return `FULL_BYTE_M;
            7'h02: return `HARDWARE_CONFIGURATION_M;
            7'h03: return `WATCHDOG_CONTROL_M;
            7'h05: return `TRANSCEIVER_CONTROL_SECOND_M;
            7'h10: return `SWITCH_SHUTDOWN_CONTROL_M;
            7'h1c: return `PULSE_WIDTH_FREQUENCY_M;
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, ad};
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= dt;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic frame(input logic w, input logic [6:0] ad, input logic [7:0] dt);
        int n;
        n = 0;
        ahb(1, `HOST_CMD_OFS, {16'h0, dt, w, ad});
        do begin
            ahb(0, `HOST_STATUS_OFS, 0);
            n++;
        end while (rd[0] === 1'b1 && n < 400);
        chk("busy", 0, rd[15:0]);
        chk("wire", {dt, w, ad}, wire_q);
        ahb(0, `HOST_RX_OFS, 0);
    endtask
    task automatic cmp_all();
        for (int i = 0; i < 32; i++) chk("ctrl", {8'h00, model[i]}, {8'h00, ctrl_regs[i]});
    endtask
    task automatic results();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // lsb goes first on the wire, so shift in from the top
    always @(posedge lk.sclk) wire_q <= {lk.mosi, wire_q[15:1]};
    initial begin
        #400000;
        errors++;
        results();
    end
    initial begin
        {hresetn, hwrite, restart_pulse, hw_we, htrans, haddr, hwdata} = '0;
        {hw_addr, hw_data, wake_lvl, stat_evt, wire_q} = '0;
        foreach (model[i]) model[i] = 8'h00;
        void'($urandom(32'h8cea0d20));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        cmp_all();
        frame(1, `FAMILY_PRODUCT_ID_A, 8'hff);
        frame(0, `FAMILY_PRODUCT_ID_A, 8'h00);
        chk("id", {FAM, 8'h00}, rd[15:0]);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            a = tbl[$urandom % 9];
            d = 8'($urandom);
            if (a == 7'h01) d[7] = 1'b0; // keeps random data off the soft reset code
            if (i % 2) d = d & wmask(a);
            old = a[6:5] == 2'b00 ? model[a[4:0]] : 8'h00;
            frame(1, a, d);
            chk("old", {old, 8'h00}, rd[15:0]);
            if (a[6:5] == 2'b00) model[a[4:0]] = d & wmask(a);
            frame(0, a, 8'h00);
            chk("read", {a[6:5] == 2'b00 ? model[a[4:0]] : 8'h00, 8'h00}, rd[15:0]);
            cmp_all();
        end
        $display("test random done");
        wake_lvl <= 8'($urandom);
        stat_evt[2] <= 8'h05;
        @(posedge hclk);
        stat_evt[2] <= 8'h00;
        frame(0, `WAKE_INPUT_LEVEL_STATUS_A, 8'h00);
        chk("level", {wake_lvl & `WAKE_INPUT_LEVEL_STATUS_M, 8'h01}, rd[15:0]);
        frame(0, `THERMAL_STATUS_A, 8'h00);
        chk("flags", 16'h0501, rd[15:0]);
        frame(1, `THERMAL_STATUS_A, 8'hff);
        chk("cleared", 16'h0000, rd[15:0]);
        $display("test status done");
        frame(1, 7'h01, 8'h3f);
        restart_pulse <= 1'b1;
        @(posedge hclk);
        restart_pulse <= 1'b0;
        model[1] = 8'h3f & `MODE_SUPPLY_CONTROL_K;
        model[2] = model[2] & `HARDWARE_CONFIGURATION_K;
        repeat (2) @(posedge hclk);
        cmp_all();
        hw_addr <= 7'h01;
        hw_data <= 8'h7c;
        hw_we <= 1'b1;
        @(posedge hclk);
        hw_addr <= 7'h03;
        hw_data <= 8'hff;
        @(posedge hclk);
        hw_we <= 1'b0;
        model[1] = (model[1] & ~`MODE_SUPPLY_CONTROL_H) | (8'h7c & `MODE_SUPPLY_CONTROL_H);
        repeat (2) @(posedge hclk);
        cmp_all();
        frame(1, 7'h01, 8'hc0);
        chk("old", {model[1], 8'h00}, rd[15:0]);
        foreach (model[i]) model[i] = 8'h00;
        cmp_all();
        $display("test restart done");
        ahb(1, `HOST_IRQ_MASK_OFS, 1);
        ahb(0, `HOST_IRQ_MASK_OFS, 0);
        chk("mask", 1, {hresp, rd[14:0]});
        ahb(0, `HOST_IRQ_STAT_OFS, 0);
        frame(0, 7'h1e, 8'h00);
        chk("irq", 16'h0001, {15'h0, irq});
        ahb(0, `HOST_IRQ_STAT_OFS, 0);
        chk("done", 16'h0001, rd[15:0]);
        ahb(0, `HOST_IRQ_STAT_OFS, 0);
        chk("irq", 16'h0000, {rd[14:0], irq});
        ahb(1, `HOST_IRQ_MASK_OFS, 0);
        frame(0, 7'h1e, 8'h00);
        chk("masked", 16'h0000, {15'h0, irq});
        ahb(0, 8'h20, 0);
        chk("unmapped", 16'h0000, rd[15:0]);
        $display("test irq done");
        results();
    end
endmodule
